/* File: include/bsf_pkg.sv */
package bsf_pkg;
  // ==========================================
  // Command codes served here
  localparam logic [7:0] CMD_STATUS_WORD = 8'h16;
  localparam logic [7:0] CMD_CYCLE_TOTAL = 8'h17;
  localparam logic [7:0] CMD_NOM_CAPACITY = 8'h18;
  localparam logic [7:0] CMD_NOM_VOLTAGE = 8'h19;
  // ==========================================
  // Status word bit positions
  localparam int BIT_OVER_CHARGED = 15;
  localparam int BIT_TERM_CHARGE = 14;
  localparam int BIT_OVER_TEMP = 12;
  localparam int BIT_TERM_DISCHARGE = 11;
  localparam int BIT_CAP_ALARM = 9;
  localparam int BIT_TIME_ALARM = 8;
  localparam int BIT_INITIALIZED = 7;
  localparam int BIT_DISCHARGING = 6;
  localparam int BIT_FULL_CHARGED = 5;
  localparam int BIT_FULL_DISCHARGED = 4;
  localparam int ERR_LSB = 0;
  localparam int ERR_W = 3;
  // ==========================================
  // Error codes
  localparam logic [2:0] ERR_OK = 3'h0;
  localparam logic [2:0] ERR_BUSY = 3'h1;
  localparam logic [2:0] ERR_RESERVED = 3'h2;
  localparam logic [2:0] ERR_UNSUPPORTED = 3'h3;
  localparam logic [2:0] ERR_WRITE_PROTECTED = 3'h4;
  localparam logic [2:0] ERR_OVERFLOW = 3'h5;
  localparam logic [2:0] ERR_WRONG_LENGTH = 3'h6;
  localparam logic [2:0] ERR_UNKNOWN = 3'h7;
  // ==========================================
  // Data-flash locations
  localparam logic [7:0] DF_ADDR_NOM_VOLTAGE = 8'h04;
  localparam logic [7:0] DF_ADDR_CYCLE_TOTAL = 8'h0C;
  localparam logic [7:0] DF_ADDR_CYCLE_THRESHOLD = 8'h37;
  localparam logic [7:0] DF_ADDR_FULL_CLEAR_PCT = 8'h47;
  // ==========================================
  // Limits
  localparam logic [6:0] FULL_DSG_CLEAR_PCT = 7'h14;
  localparam logic [1:0] OVER_CHG_CLEAR_MAH = 2'h2;
  localparam logic [15:0] CYCLE_TOTAL_MAX = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage

/* File: hw/bsf_cycle_counter.sv */
`timescale 1ns/10ps
module bsf_cycle_counter
  import bsf_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic mah_tick, // One mAh discharged
  input wire logic [15:0] threshold, // mAh per cycle
  input wire logic load, // Restore from data flash
  input wire logic [15:0] load_value, // Stored cycle total
  output logic [15:0] count, // Cycle total
  output logic wr_pulse // Count changed, save it
);
  logic [15:0] acc;
  logic hit;

  // Zero threshold would count once per 65536 ticks; treat as disabled
  assign hit = mah_tick && (threshold != WORD_ZERO) && (acc >= threshold - 16'h0001);

  always_ff @(posedge core_clk)
  begin
    if (rst || load)
      acc <= WORD_ZERO;
    else if (hit)
      acc <= WORD_ZERO;
    else if (mah_tick)
      acc <= acc + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      count <= WORD_ZERO;
    else if (load)
      count <= load_value;
    else if (hit && count != CYCLE_TOTAL_MAX)
      count <= count + 16'h0001;
  end

  // Saturated total is not rewritten to flash
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wr_pulse <= 1'b0;
    else
      wr_pulse <= hit && !load && count != CYCLE_TOTAL_MAX;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_cycle_saturates: assert property ($past(count) == CYCLE_TOTAL_MAX && !$past(load) |-> count == CYCLE_TOTAL_MAX)
    else $error("cycle total wrapped past saturation");
  chk_cycle_write_step: assert property (wr_pulse |-> count == $past(count) + 16'h0001 || $past(load))
    else $error("flash save without a count step");
endmodule

/* File: hw/bsf_status_regs.sv */
`timescale 1ns/10ps
// How it works
// - Set over-charged alarm on overcharge
// - Clear after charge stops, 2 mAh discharge
// - Set terminate-charge on fault or termination
// - Clear terminate-charge when fault and termination end or charge stops
// - Over-temp alarm while temp at/above max
// - Set terminate-discharge on low voltage, undervoltage
// - Clear terminate-discharge only when all good
// - Set capacity alarm below threshold
// - Clear capacity alarm on lower threshold/charging
// - Runtime alarm set and clear likewise
// - Initialized follows data-flash load validity
// - Discharging flag is not-charging
// - Fully-charged set on termination or overcharge
// - Fully-charged clear below flash percentage
// - Fully-discharged set on low voltage/percentage
// - Fully-discharged clear at 20 percent
// - Write-protected, wrong-length, busy errors
// - Reserved, unimplemented, overflow, unknown errors
// - Cycle total read at 0x17, saturating
// - Cycle step per threshold, saved to flash
// - Nominal capacity at 0x18, unit by mode
// - Nominal voltage at 0x19 from flash
module bsf_status_regs
  import bsf_pkg::*;
(
  input wire logic core_clk, // 125 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic chg_active, // Charging detected
  input wire logic dsg_mah_tick, // 1 mAh discharge or idle accrued
  input wire logic overcharge_det, // Charge past overcharge limit
  input wire logic chg_param_fault, // Charge V, I or T out of range
  input wire logic prim_term_det, // Primary charge termination
  input wire logic [15:0] pack_temp, // Internal temperature
  input wire logic [15:0] max_temp, // Max temperature threshold
  input wire logic [15:0] pack_voltage, // Pack voltage, mV
  input wire logic [15:0] term_voltage, // Terminate voltage, mV
  input wire logic [15:0] chg_current, // Charging current, mA
  input wire logic cell_undervoltage_bit, // A cell below its limit
  input wire logic [15:0] cell_voltage, // Lowest cell voltage
  input wire logic [15:0] first_end_of_discharge_threshold, // First EOD level
  input wire logic signed [15:0] pack_current, // Signed pack current
  input wire logic signed [15:0] overload_current, // Overload current
  input wire logic [15:0] capacity_left, // Remaining capacity
  input wire logic [15:0] capacity_alarm_threshold, // Host capacity alarm
  input wire logic [15:0] run_time_left, // Time left at present rate
  input wire logic [15:0] runtime_alarm_threshold, // Host time alarm
  input wire logic [15:0] mean_time_left, // Averaged time to empty
  input wire logic [6:0] charge_percentage, // Relative charge, percent
  input wire logic [6:0] battery_low_pct, // Battery-low percent
  input wire logic [6:0] df_full_clear_pct, // Fully-charged clear percent
  input wire logic df_load_done, // Flash load finished, pulse
  input wire logic df_load_valid, // Flash load was proper
  input wire logic [15:0] df_cycle_total, // Stored cycle total
  input wire logic [15:0] df_cycle_threshold, // mAh per cycle
  input wire logic [15:0] df_nom_voltage, // Stored nominal voltage
  input wire logic [15:0] nom_capacity_mah, // Nominal capacity, mAh
  input wire logic [15:0] nom_capacity_cwh, // Nominal capacity, 10 mWh
  input wire logic capacity_mode, // Mode word capacity-units bit
  input wire logic txn_valid, // Transaction done, pulse
  input wire logic [7:0] txn_cmd, // Function code
  input wire logic txn_write, // Transaction was a write
  input wire logic txn_len_ok, // Write block length correct
  input wire logic txn_defined, // Code defined by the standard
  input wire logic txn_mfg, // Optional manufacturer code
  input wire logic txn_served_ext, // Code served by other logic
  input wire logic txn_ext_ro, // External code is read-only
  input wire logic txn_overflow, // Data over/underflow seen
  input wire logic txn_unknown, // Unidentified error seen
  input wire logic core_busy, // Cannot process now
  output logic rsp_valid, // Read word ready, pulse
  output logic [15:0] rsp_data, // Read word
  output logic [15:0] status_word, // Alarm, status and error word
  output logic df_wr_req, // Save cycle total, pulse
  output logic [7:0] df_wr_addr, // Flash address for save
  output logic [15:0] df_wr_data // Cycle total to save
);
  logic over_chg, term_chg, over_temp, term_dsg, cap_alarm, time_alarm;
  logic initialized, discharging, full_chg, full_dsg;
  logic [2:0] err_code;
  logic [2:0] next_err;
  logic [1:0] dsg_mah;
  logic [15:0] cap_prev, mtl_prev;
  logic [15:0] cycle_total;
  logic cycle_wr;
  logic own_cmd, own_or_ext;

  bsf_cycle_counter u_cycle (
    .core_clk(core_clk),
    .rst(rst),
    .mah_tick(dsg_mah_tick && !chg_active),
    .threshold(df_cycle_threshold),
    .load(df_load_done && df_load_valid),
    .load_value(df_cycle_total),
    .count(cycle_total),
    .wr_pulse(cycle_wr)
  );

  // ==========================================
  // Alarm flags
  // Discharge accrual restarts whenever charge resumes
  always_ff @(posedge core_clk)
  begin
    if (rst || chg_active)
      dsg_mah <= 2'h0;
    else if (dsg_mah_tick && dsg_mah != OVER_CHG_CLEAR_MAH)
      dsg_mah <= dsg_mah + 2'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      over_chg <= 1'b0;
    else if (overcharge_det)
      over_chg <= 1'b1;
    else if (!chg_active && dsg_mah == OVER_CHG_CLEAR_MAH)
      over_chg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      term_chg <= 1'b0;
    else if (chg_active && (chg_param_fault || prim_term_det))
      term_chg <= 1'b1;
    else
      term_chg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      over_temp <= 1'b0;
    else
      over_temp <= pack_temp >= max_temp;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      term_dsg <= 1'b0;
    else if (pack_voltage <= term_voltage || cell_undervoltage_bit)
      term_dsg <= 1'b1;
    else if (chg_current != WORD_ZERO)
      term_dsg <= 1'b0;
  end

  // Previous values detect a rise caused by charging
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cap_prev <= WORD_ZERO;
      mtl_prev <= WORD_ZERO;
    end
    else
    begin
      cap_prev <= capacity_left;
      mtl_prev <= mean_time_left;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cap_alarm <= 1'b0;
    else if (capacity_left < capacity_alarm_threshold)
      cap_alarm <= 1'b1;
    else if (capacity_alarm_threshold < capacity_left || (chg_active && capacity_left > cap_prev))
      cap_alarm <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      time_alarm <= 1'b0;
    else if (run_time_left < runtime_alarm_threshold)
      time_alarm <= 1'b1;
    else if (runtime_alarm_threshold < mean_time_left || (chg_active && mean_time_left > mtl_prev))
      time_alarm <= 1'b0;
  end

  // ==========================================
  // Status flags
  always_ff @(posedge core_clk)
  begin
    if (rst)
      initialized <= 1'b0;
    else if (df_load_done)
      initialized <= df_load_valid;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      discharging <= 1'b1;
    else
      discharging <= !chg_active;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      full_chg <= 1'b0;
    else if (prim_term_det || overcharge_det)
      full_chg <= 1'b1;
    else if (charge_percentage < df_full_clear_pct)
      full_chg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      full_dsg <= 1'b0;
    else if (((pack_voltage < first_end_of_discharge_threshold || cell_voltage < first_end_of_discharge_threshold)
              && pack_current < overload_current) || charge_percentage < battery_low_pct)
      full_dsg <= 1'b1;
    else if (charge_percentage >= FULL_DSG_CLEAR_PCT)
      full_dsg <= 1'b0;
  end

  // ==========================================
  // Transaction error code
  assign own_cmd = txn_cmd == CMD_STATUS_WORD || txn_cmd == CMD_CYCLE_TOTAL
                   || txn_cmd == CMD_NOM_CAPACITY || txn_cmd == CMD_NOM_VOLTAGE;
  assign own_or_ext = own_cmd || txn_served_ext;

  // Fixed priority: busy beats code checks, code checks beat data checks
  always_comb
  begin
    next_err = ERR_OK;
    if (core_busy)
      next_err = ERR_BUSY;
    else if (!txn_defined || (txn_mfg && !own_or_ext))
      next_err = ERR_RESERVED;
    else if (!own_or_ext)
      next_err = ERR_UNSUPPORTED;
    else if (txn_write && (own_cmd || txn_ext_ro))
      next_err = ERR_WRITE_PROTECTED;
    else if (txn_write && !txn_len_ok)
      next_err = ERR_WRONG_LENGTH;
    else if (txn_overflow)
      next_err = ERR_OVERFLOW;
    else if (txn_unknown)
      next_err = ERR_UNKNOWN;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      err_code <= ERR_OK;
    else if (txn_valid)
      err_code <= next_err;
  end

  // ==========================================
  // Read-word responses
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rsp_valid <= 1'b0;
    else
      rsp_valid <= txn_valid && !txn_write && own_cmd && next_err == ERR_OK;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rsp_data <= WORD_ZERO;
    else if (txn_valid && !txn_write)
    begin
      if (txn_cmd == CMD_CYCLE_TOTAL)
        rsp_data <= cycle_total;
      else if (txn_cmd == CMD_NOM_CAPACITY)
        rsp_data <= capacity_mode ? nom_capacity_cwh : nom_capacity_mah;
      else if (txn_cmd == CMD_NOM_VOLTAGE)
        rsp_data <= df_nom_voltage;
      else if (txn_cmd == CMD_STATUS_WORD)
        rsp_data <= status_word;
      else
        rsp_data <= WORD_ZERO;
    end
  end

  // Status word lags flags by one cycle so the output is a flop
  always_ff @(posedge core_clk)
  begin
    if (rst)
      status_word <= WORD_ZERO;
    else
    begin
      status_word <= WORD_ZERO;
      status_word[BIT_OVER_CHARGED] <= over_chg;
      status_word[BIT_TERM_CHARGE] <= term_chg;
      status_word[BIT_OVER_TEMP] <= over_temp;
      status_word[BIT_TERM_DISCHARGE] <= term_dsg;
      status_word[BIT_CAP_ALARM] <= cap_alarm;
      status_word[BIT_TIME_ALARM] <= time_alarm;
      status_word[BIT_INITIALIZED] <= initialized;
      status_word[BIT_DISCHARGING] <= discharging;
      status_word[BIT_FULL_CHARGED] <= full_chg;
      status_word[BIT_FULL_DISCHARGED] <= full_dsg;
      status_word[ERR_LSB +: ERR_W] <= err_code;
    end
  end

  // ==========================================
  // Data-flash save of the cycle total
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      df_wr_req <= 1'b0;
      df_wr_addr <= DF_ADDR_CYCLE_TOTAL;
      df_wr_data <= WORD_ZERO;
    end
    else
    begin
      df_wr_req <= cycle_wr;
      df_wr_addr <= DF_ADDR_CYCLE_TOTAL;
      df_wr_data <= cycle_total;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_own_write;
    txn_valid && txn_write && own_cmd && txn_defined && !core_busy;
  endsequence

  sequence s_clean_own_read;
    txn_valid && !txn_write && own_cmd && txn_defined && !txn_mfg && !core_busy && !txn_overflow && !txn_unknown;
  endsequence

  chk_overchg_set: assert property (overcharge_det |=> over_chg)
    else $error("over-charged alarm not set");
  chk_overchg_hold: assert property ($fell(over_chg) |-> $past(!chg_active) && $past(dsg_mah) == OVER_CHG_CLEAR_MAH)
    else $error("over-charged alarm cleared early");
  chk_termchg_follow: assert property (chg_active && (chg_param_fault || prim_term_det) |=> term_chg)
    else $error("terminate-charge alarm wrong");
  chk_termchg_clear: assert property (!chg_active |=> !term_chg)
    else $error("terminate-charge alarm kept off charge");
  chk_overtemp_level: assert property (pack_temp >= max_temp |=> over_temp)
    else $error("over-temperature alarm missed");
  chk_termdsg_set: assert property (cell_undervoltage_bit |=> term_dsg)
    else $error("terminate-discharge alarm missed");
  chk_termdsg_clear: assert property ($fell(term_dsg) |-> $past(pack_voltage) > $past(term_voltage)
                                      && $past(chg_current) != WORD_ZERO && !$past(cell_undervoltage_bit))
    else $error("terminate-discharge alarm cleared early");
  chk_cap_alarm: assert property (capacity_left < capacity_alarm_threshold |=> cap_alarm)
    else $error("capacity alarm missed");
  chk_cap_clear: assert property (capacity_alarm_threshold < capacity_left && capacity_left >= capacity_alarm_threshold
                                  |=> !cap_alarm)
    else $error("capacity alarm not cleared");
  chk_time_alarm: assert property (run_time_left < runtime_alarm_threshold |=> time_alarm)
    else $error("runtime alarm missed");
  chk_init_load: assert property (df_load_done |=> initialized == $past(df_load_valid))
    else $error("initialized flag wrong");
  chk_dsg_flag: assert property (chg_active |=> !discharging ##1 !status_word[BIT_DISCHARGING])
    else $error("discharging flag wrong");
  chk_full_chg: assert property (prim_term_det |=> full_chg)
    else $error("fully-charged not set");
  chk_full_clr: assert property (!prim_term_det && !overcharge_det && charge_percentage < df_full_clear_pct
                                 |=> !full_chg)
    else $error("fully-charged not cleared");
  chk_full_dsg: assert property (charge_percentage < battery_low_pct |=> full_dsg)
    else $error("fully-discharged not set");
  chk_full_dsg_clr: assert property ($fell(full_dsg) |-> $past(charge_percentage) >= FULL_DSG_CLEAR_PCT)
    else $error("fully-discharged cleared early");
  chk_err_protect: assert property (s_own_write |=> err_code == ERR_WRITE_PROTECTED)
    else $error("write to read-only code not refused");
  chk_err_busy: assert property (txn_valid && core_busy |=> err_code == ERR_BUSY ##1 status_word[2:0] == ERR_BUSY)
    else $error("busy error not reported");
  chk_err_reserved: assert property (txn_valid && !core_busy && !txn_defined |=> err_code == ERR_RESERVED)
    else $error("reserved code not reported");
  chk_cycle_read: assert property (s_clean_own_read ##0 txn_cmd == CMD_CYCLE_TOTAL
                                   |=> rsp_valid && rsp_data == $past(cycle_total))
    else $error("cycle total read wrong");
  chk_df_save: assert property (cycle_wr |=> df_wr_req && df_wr_addr == DF_ADDR_CYCLE_TOTAL)
    else $error("cycle total not saved");
  chk_cap_read: assert property (s_clean_own_read ##0 txn_cmd == CMD_NOM_CAPACITY && capacity_mode
                                 |=> rsp_data == $past(nom_capacity_cwh))
    else $error("capacity unit wrong");
  chk_volt_read: assert property (s_clean_own_read ##0 txn_cmd == CMD_NOM_VOLTAGE
                                  |=> rsp_data == $past(df_nom_voltage))
    else $error("nominal voltage read wrong");
  chk_err_ok: assert property (s_clean_own_read |=> err_code == ERR_OK ##1 status_word[2:0] == ERR_OK)
    else $error("clean transaction did not load OK");
endmodule

/* File: dv/bsf_host_model.sv */
`timescale 1ns/10ps
module bsf_host_model
(
  input wire logic core_clk, // System clock
  output logic txn_valid, // Transaction done
  output logic [7:0] txn_cmd, // Function code
  output logic txn_write, // Write access
  output logic txn_len_ok, // Block length right
  output logic txn_defined, // Standard code
  output logic txn_mfg, // Manufacturer code
  output logic txn_served_ext, // Served elsewhere
  output logic txn_ext_ro, // Elsewhere read-only
  output logic txn_overflow, // Data overflow
  output logic txn_unknown, // Odd error
  output logic core_busy // Core cannot serve
);
  // Qualifiers are inverted between transfers so a stale value is never trusted
  initial
  begin
    txn_valid = 1'b0;
    txn_cmd = 8'h00;
    {txn_write, txn_len_ok, txn_defined, txn_mfg, txn_served_ext, txn_ext_ro, txn_overflow, txn_unknown,
      core_busy} = 9'h000;
  end
  task automatic xfer(input logic [7:0] c, input logic [8:0] f, input int gap);
    @(posedge core_clk);
    txn_valid <= 1'b1;
    txn_cmd <= c;
    {txn_write, txn_len_ok, txn_defined, txn_mfg, txn_served_ext, txn_ext_ro, txn_overflow, txn_unknown,
      core_busy} <= f;
    @(posedge core_clk);
    txn_valid <= 1'b0;
    txn_cmd <= ~c;
    {txn_write, txn_len_ok, txn_defined, txn_mfg, txn_served_ext, txn_ext_ro, txn_overflow, txn_unknown,
      core_busy} <= ~f;
    repeat (gap) @(posedge core_clk);
  endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb
  import bsf_pkg::*;
;
  logic core_clk, rst, chg_active, dsg_mah_tick, overcharge_det, chg_param_fault, prim_term_det;
  logic cell_undervoltage_bit, df_load_done, df_load_valid, capacity_mode, rsp_valid, df_wr_req;
  logic txn_valid, txn_write, txn_len_ok, txn_defined, txn_mfg, txn_served_ext, txn_ext_ro;
  logic txn_overflow, txn_unknown, core_busy, ec, et, eo;
  logic [15:0] pack_temp, max_temp, pack_voltage, term_voltage, chg_current, cell_voltage, e_mon;
  logic [15:0] first_end_of_discharge_threshold, capacity_left, capacity_alarm_threshold, run_time_left;
  logic [15:0] runtime_alarm_threshold, mean_time_left, df_cycle_total, df_cycle_threshold, df_nom_voltage;
  logic [15:0] nom_capacity_mah, nom_capacity_cwh, rsp_data, status_word, df_wr_data;
  logic signed [15:0] pack_current, overload_current;
  logic [6:0] charge_percentage, battery_low_pct, df_full_clear_pct;
  logic [7:0] txn_cmd, df_wr_addr;
  logic [15:0] exp_q[$];
  logic [15:0] save_q[$];
  logic [31:0] r, s;
  int fails, checks_done;
  logic [8:0] et_f[10] = '{9'h041, 9'h000, 9'h060, 9'h040, 9'h1C0, 9'h158, 9'h150, 9'h054, 9'h052, 9'h050};
  logic [7:0] et_c[10] = '{8'h30, 8'h40, 8'h50, 8'h1D, 8'h17, 8'h1A, 8'h1A, 8'h1A, 8'h1A, 8'h1A};
  logic [2:0] et_e[10] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h6, 3'h5, 3'h7, 3'h0};

  bsf_status_regs dut (.*);
  bsf_host_model host (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chkf(input logic [15:0] m, input logic [15:0] e);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("flags", e, status_word & m)
    @(posedge core_clk);
  endtask
  task automatic tx(input logic [7:0] c, input logic [8:0] f, input logic [2:0] e, input int gap);
    host.xfer(c, f, gap);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("err_code", e, status_word[2:0])
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    tx(c, 9'h040, ERR_OK, 0);
  endtask
  task automatic tick;
    dsg_mah_tick <= 1'b1;
    @(posedge core_clk);
    dsg_mah_tick <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic ld(input logic v);
    df_load_valid <= v;
    df_load_done <= 1'b1;
    @(posedge core_clk);
    df_load_done <= 1'b0;
    chkf(16'h0080, {8'h00, v, 7'h00});
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================
  // Result watcher
  always @(posedge core_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      e_mon = (exp_q.size() > 0) ? exp_q.pop_front() : ~rsp_data;
      `CHK("rsp_data", e_mon, rsp_data)
    end
    if (df_wr_req === 1'b1)
    begin
      e_mon = (save_q.size() > 0) ? save_q.pop_front() : ~df_wr_data;
      `CHK("df_wr_data", e_mon, df_wr_data)
      `CHK("df_wr_addr", DF_ADDR_CYCLE_TOTAL, df_wr_addr)
    end
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("ERROR timeout exp 0 got 1");
    end_of_test;
  end

  // ==========================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    {chg_active, dsg_mah_tick, overcharge_det, chg_param_fault, prim_term_det} = 5'h00;
    {cell_undervoltage_bit, df_load_done, df_load_valid, capacity_mode} = 4'h0;
    {pack_temp, max_temp, pack_voltage, term_voltage} = {16'h0019, 16'h003C, 16'h3A98, 16'h2EE0};
    {chg_current, cell_voltage, first_end_of_discharge_threshold} = {16'h01F4, 16'h0FA0, 16'h00C8};
    {capacity_left, capacity_alarm_threshold, run_time_left} = {16'h03E8, 16'h0064, 16'h01F4};
    {runtime_alarm_threshold, mean_time_left, df_cycle_total} = {16'h000A, 16'h01F4, 16'hFFFE};
    {df_cycle_threshold, df_nom_voltage, nom_capacity_mah, nom_capacity_cwh} = {16'h0000, 16'h2A30, 16'h0BB8, 16'h0A8C};
    {pack_current, overload_current} = {16'h0010, 16'h03E8};
    {charge_percentage, battery_low_pct, df_full_clear_pct} = {7'h32, 7'h0A, 7'h28};
    {fails, checks_done} = 0;
    {r, ec, et} = {32'h0000_0001, 2'h0};
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    chkf(16'hFFFF, 16'h0040);
    ld(1'b1);
    ld(1'b0);
    ld(1'b1);
    $display("test reset_load done");
    for (int m = 0; m < 2; m++)
    begin
      capacity_mode <= m[0];
      rd(CMD_NOM_CAPACITY, m[0] ? nom_capacity_cwh : nom_capacity_mah);
    end
    rd(CMD_CYCLE_TOTAL, 16'hFFFE);
    rd(CMD_NOM_VOLTAGE, df_nom_voltage);
    rd(CMD_STATUS_WORD, 16'h00C0);
    for (int i = 0; i < 10; i++)
      tx(et_c[i], et_f[i], et_e[i], i % 3);
    $display("test reads_errors done");
    chg_active <= 1'b1;
    overcharge_det <= 1'b1;
    chkf(16'hC060, 16'h8020);
    overcharge_det <= 1'b0;
    chg_param_fault <= 1'b1;
    chkf(16'hC000, 16'hC000);
    chg_param_fault <= 1'b0;
    chkf(16'hC000, 16'h8000);
    prim_term_det <= 1'b1;
    chkf(16'h4000, 16'h4000);
    chg_active <= 1'b0;
    chkf(16'hC060, 16'h8060);
    prim_term_det <= 1'b0;
    tick();
    chkf(16'h8000, 16'h8000);
    tick();
    chkf(16'h8000, 16'h0000);
    charge_percentage <= 7'h28;
    chkf(16'h0020, 16'h0020);
    charge_percentage <= 7'h27;
    chkf(16'h0020, 16'h0000);
    $display("test charge_flags done");
    pack_voltage <= 16'h2EE0;
    chkf(16'h0800, 16'h0800);
    {pack_voltage, chg_current} <= {16'h3A98, 16'h0000};
    chkf(16'h0800, 16'h0800);
    {chg_current, cell_undervoltage_bit} <= {16'h01F4, 1'b1};
    chkf(16'h0800, 16'h0800);
    cell_undervoltage_bit <= 1'b0;
    chkf(16'h0800, 16'h0000);
    charge_percentage <= 7'h09;
    chkf(16'h0010, 16'h0010);
    charge_percentage <= 7'h13;
    chkf(16'h0010, 16'h0010);
    charge_percentage <= 7'h14;
    chkf(16'h0010, 16'h0000);
    {cell_voltage, pack_current} <= {16'h0064, 16'hFFFB};
    chkf(16'h0010, 16'h0010);
    cell_voltage <= 16'h0FA0;
    chkf(16'h0010, 16'h0000);
    $display("test discharge_flags done");
    for (int i = 0; i < 24; i++)
    begin
      r = xs(r);
      s = xs(r);
      {capacity_left, capacity_alarm_threshold} <= {6'h00, r[9:0], 6'h00, r[19:10]};
      {pack_temp, max_temp} <= {11'h000, r[24:20], 11'h000, r[29:25]};
      {run_time_left, runtime_alarm_threshold, mean_time_left} <= {8'h00, s[7:0], 8'h00, s[15:8], 8'h00, s[23:16]};
      ec = (r[9:0] < r[19:10]) ? 1'b1 : ((r[19:10] < r[9:0]) ? 1'b0 : ec);
      et = (s[7:0] < s[15:8]) ? 1'b1 : ((s[15:8] < s[23:16]) ? 1'b0 : et);
      eo = r[24:20] >= r[29:25];
      chkf(16'h1300, {3'h0, eo, 2'h0, ec, et, 8'h00});
    end
    $display("test random_alarms done");
    df_cycle_threshold <= 16'h0002;
    save_q.push_back(16'hFFFF);
    tick();
    tick();
    rd(CMD_CYCLE_TOTAL, 16'hFFFF);
    tick();
    tick();
    tick();
    rd(CMD_CYCLE_TOTAL, 16'hFFFF);
    repeat (4) @(posedge core_clk);
    `CHK("pending", 0, exp_q.size() + save_q.size())
    $display("test cycle_total done");
    end_of_test;
  end
endmodule
